// ---- core/sfp_pkg.sv ----
/*
  Shared constants of the sample buffer and proximity control block:
  register offsets, field positions, reset values and the mode type.
  Assumes an 8-bit register port with byte-wide offsets.
*/
package sfp_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_IRQ_STATUS_FIRST  = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS_SECOND = 8'h01;
  localparam logic [7:0] OFS_IRQ_ENABLE_SECOND = 8'h03;
  localparam logic [7:0] OFS_WRITE_INDEX       = 8'h04;
  localparam logic [7:0] OFS_LOST_COUNT        = 8'h05;
  localparam logic [7:0] OFS_READ_INDEX        = 8'h06;
  localparam logic [7:0] OFS_DATA_PORT         = 8'h07;
  localparam logic [7:0] OFS_BUFFER_CONFIG     = 8'h08;
  localparam logic [7:0] OFS_ITEM_CTRL_LOW     = 8'h09;
  localparam logic [7:0] OFS_ITEM_CTRL_HIGH    = 8'h0A;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_SUPPLY_EN   = 7;
  localparam int BIT_CLR_ON_DATA = 6;
  localparam int BIT_AF_SINGLE   = 5;
  localparam int BIT_ROLLOVER    = 4;
  localparam int NEAR_SHIFT      = 11;
  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0] RST_IRQ_ENABLE_SECOND = 8'h00;
  localparam logic [7:0] RST_BUFFER_CONFIG     = 8'h0F;
  localparam logic [7:0] RST_ITEM_CTRL         = 8'h00;
  localparam logic [4:0] RST_INDEX             = 5'h00;
  localparam logic [4:0] LOST_MAX              = 5'h1F;
  localparam int         BUF_DEPTH             = 32;
  localparam int         SYNC_STAGES           = 3;
  // ****************************************
  // Acquisition mode
  // ****************************************
  typedef enum logic [0:0] {
    SFP_NORMAL = 1'b0,
    SFP_NEAR   = 1'b1
  } sfp_mode_e;
endpackage : sfp_pkg

// ---- core/sfp_sync.sv ----
/*
  Three-stage synchroniser for a level arriving from outside the clock domain.
  Assumes the caller holds clk_en high for the stages to advance.
*/
`timescale 1ns/10ps
module sfp_sync
  import sfp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);
  // ****************************************
  // Stages
  // ****************************************
  logic [SYNC_STAGES-1:0] stage;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      stage <= '0;
    end
    else if (clk_en)
    begin
      stage <= {stage[SYNC_STAGES-2:0], async_in};
    end
  end

  // Change accepted once the second and third stages agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_out <= 1'b0;
    end
    else if (clk_en && (stage[1] == stage[2]))
    begin
      sync_out <= stage[2];
    end
  end
endmodule : sfp_sync

// ---- core/sfp_ctrl.sv ----
/*
  Sample buffer with pointers, lost-sample count, almost-full flag policy,
  item type selection and proximity-mode control.
  Assumes a register port decoded from the serial interface outside, a sample
  push from the conversion path, and system settings given as plain inputs.
*/
// Function
// RQ1: Host sets item 1 to first LED when proximity interrupt is enabled.
// RQ2: Near mode when LED1 value below 2048 times threshold, else normal.
// RQ3: Near mode acquires one LED1 exposure at pilot amplitude.
// RQ4: Normal mode acquires all configured items with their currents.
// RQ5: Proximity flag set on leaving near mode when enabled.
// RQ6: Compliance enable gates the LED1 compliance flag.
// RQ7: Bit 7 of second enable register gates supply flag, resets 0.
// RQ8: Five-bit write index resets zero, advances per pushed sample.
// RQ9: Five-bit lost-sample count saturates at 0x1F.
// RQ10: Five-bit read index resets zero, advances per popped sample.
// RQ11: Host may write read index to reread samples.
// RQ12: Data port read returns entry at read index; read only.
// RQ13: Clear-on-data bit adds data read as almost-full clear.
// RQ14: Repeat type re-asserts almost-full on every sample while condition holds.
// RQ15: Single type asserts once per fresh almost-full condition.
// RQ16: Rollover on full overwrites oldest, both indexes advance.
// RQ17: Stop on full discards samples, write index held.
// RQ18: Near mode pushes into full buffer regardless of rollover.
// RQ19: Almost-full fires at 32 minus threshold samples; reset 0xF.
// RQ20: Low item register holds item 1 and item 2 types.
// RQ21: High item register holds item 3 and item 4 types.
// RQ22: Almost-full flag shows next sample passes threshold.
// RQ23: Proximity flag clears on first status register read.
// RQ24: Enable rise flushes buffer; enable low stops pushes, holds state.
// RQ25: Indexes wrap modulo 32.
`timescale 1ns/10ps
module sfp_ctrl
  import sfp_pkg::*;
#(
  parameter int         DATA_W    = 8,
  parameter int         ADC_W     = 19,
  parameter logic [3:0] LED1_TYPE = 4'h1
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic              led1_valid,
  input  wire logic [ADC_W-1:0]  led1_value,
  input  wire logic [7:0]        near_detect_threshold,
  input  wire logic [7:0]        pilot_led_amplitude,
  input  wire logic [7:0]        led1_amplitude,
  input  wire logic              near_irq_enable,
  input  wire logic              led_compliance_irq_enable,
  input  wire logic              buffer_enable,
  input  wire logic              led_compliance_fault,
  input  wire logic              supply_range_fault,
  output logic                   near_mode,
  output logic      [15:0]       acq_item_types,
  output logic      [7:0]        acq_led1_amplitude,
  output logic                   almost_full_flag,
  output logic                   near_flag,
  output logic                   led_compliance_flag,
  output logic                   supply_range_flag
);
  // ****************************************
  // Storage and registers
  // ****************************************
  logic [DATA_W-1:0] mem [BUF_DEPTH];
  logic [4:0]        buffer_write_index;
  logic [4:0]        buffer_read_index;
  logic [4:0]        lost_sample_count;
  logic [5:0]        fill;
  logic [7:0]        irq_enable_second;
  logic [7:0]        buffer_config;
  logic [7:0]        item_type_ctrl_low;
  logic [7:0]        item_type_ctrl_high;
  logic              enable_q;
  logic              af_cond_q;
  sfp_mode_e         mode;
  logic              compliance_s;
  logic              supply_s;

  sfp_sync u_sync_compliance (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (led_compliance_fault),
    .sync_out (compliance_s)
  );

  sfp_sync u_sync_supply (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in (supply_range_fault),
    .sync_out (supply_s)
  );

  // ****************************************
  // Decode
  // ****************************************
  logic       wr_cfg, wr_ien, wr_low, wr_high, wr_widx, wr_ridx;
  logic       rd_data, rd_stat1, rd_stat2;
  logic       flush, full, pop, push_try, push_store, push_over, lost;
  logic [5:0] af_level;
  logic       af_cond, next_af_cond;
  logic       clear_on_data, af_single, rollover;

  assign wr_ien   = reg_wr && (reg_addr == OFS_IRQ_ENABLE_SECOND);
  assign wr_widx  = reg_wr && (reg_addr == OFS_WRITE_INDEX);
  assign wr_ridx  = reg_wr && (reg_addr == OFS_READ_INDEX);
  assign wr_cfg   = reg_wr && (reg_addr == OFS_BUFFER_CONFIG);
  assign wr_low   = reg_wr && (reg_addr == OFS_ITEM_CTRL_LOW);
  assign wr_high  = reg_wr && (reg_addr == OFS_ITEM_CTRL_HIGH);
  assign rd_data  = reg_rd && (reg_addr == OFS_DATA_PORT);
  assign rd_stat1 = reg_rd && (reg_addr == OFS_IRQ_STATUS_FIRST);
  assign rd_stat2 = reg_rd && (reg_addr == OFS_IRQ_STATUS_SECOND);

  assign clear_on_data = buffer_config[BIT_CLR_ON_DATA];
  assign af_single     = buffer_config[BIT_AF_SINGLE];
  assign rollover      = buffer_config[BIT_ROLLOVER];

  // ****************************************
  // Push and pop conditions
  // ****************************************
  assign flush      = buffer_enable && !enable_q; // RQ24
  assign full       = (fill == 6'(BUF_DEPTH));
  assign pop        = rd_data && (fill != 6'h00);
  assign push_try   = sample_valid && buffer_enable && !flush; // RQ24
  assign push_store = push_try && (!full || pop || rollover || mode == SFP_NEAR); // RQ16 RQ17 RQ18
  assign push_over  = push_try && full && !pop && (rollover || mode == SFP_NEAR); // RQ16 RQ18
  assign lost       = push_try && full && !pop; // RQ9

  // RQ19
  assign af_level     = 6'(BUF_DEPTH) - {2'b00, buffer_config[3:0]};
  assign af_cond      = (fill >= af_level);
  assign next_af_cond = ((fill + 6'h01) >= af_level);

  // ****************************************
  // Buffer memory
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && push_store)
    begin
      mem[buffer_write_index] <= sample_data;
    end
  end

  // ****************************************
  // Indexes, fill and lost count
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      buffer_write_index <= RST_INDEX;
      buffer_read_index  <= RST_INDEX;
      fill               <= 6'h00;
      enable_q           <= 1'b0;
    end
    else if (clk_en)
    begin
      enable_q <= buffer_enable;
      if (flush)
      begin
        buffer_write_index <= RST_INDEX; // RQ24
        buffer_read_index  <= RST_INDEX;
        fill               <= 6'h00;
      end
      else if (wr_widx || wr_ridx)
      begin
        buffer_write_index <= wr_widx ? reg_wdata[4:0] : buffer_write_index;
        buffer_read_index  <= wr_ridx ? reg_wdata[4:0] : buffer_read_index; // RQ11
        fill <= {1'b0, (wr_widx ? reg_wdata[4:0] : buffer_write_index)
                      - (wr_ridx ? reg_wdata[4:0] : buffer_read_index)};
      end
      else
      begin
        if (push_store)
        begin
          buffer_write_index <= buffer_write_index + 5'h01; // RQ8 RQ25
        end
        if (pop || push_over)
        begin
          buffer_read_index <= buffer_read_index + 5'h01; // RQ10 RQ16 RQ25
        end
        if (push_store && !pop && !push_over)
        begin
          fill <= fill + 6'h01;
        end
        else if (pop && !push_store)
        begin
          fill <= fill - 6'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      lost_sample_count <= RST_INDEX;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        lost_sample_count <= RST_INDEX;
      end
      else if (lost && lost_sample_count != LOST_MAX)
      begin
        lost_sample_count <= lost_sample_count + 5'h01; // RQ9
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_enable_second   <= RST_IRQ_ENABLE_SECOND; // RQ7
      buffer_config       <= RST_BUFFER_CONFIG; // RQ19
      item_type_ctrl_low  <= RST_ITEM_CTRL; // RQ20
      item_type_ctrl_high <= RST_ITEM_CTRL; // RQ21
    end
    else if (clk_en)
    begin
      if (wr_ien)
      begin
        irq_enable_second <= {reg_wdata[BIT_SUPPLY_EN], 7'h00};
      end
      if (wr_cfg)
      begin
        buffer_config <= {1'b0, reg_wdata[6:0]};
      end
      if (wr_low)
      begin
        item_type_ctrl_low <= reg_wdata; // RQ20
      end
      if (wr_high)
      begin
        item_type_ctrl_high <= reg_wdata; // RQ21
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (clk_en && reg_rd)
    begin
      case (reg_addr)
        OFS_IRQ_ENABLE_SECOND: reg_rdata <= irq_enable_second;
        OFS_WRITE_INDEX:       reg_rdata <= {3'h0, buffer_write_index};
        OFS_LOST_COUNT:        reg_rdata <= {3'h0, lost_sample_count};
        OFS_READ_INDEX:        reg_rdata <= {3'h0, buffer_read_index};
        OFS_DATA_PORT:         reg_rdata <= (fill != 6'h00) ? 8'(mem[buffer_read_index]) : 8'h00; // RQ12
        OFS_BUFFER_CONFIG:     reg_rdata <= buffer_config;
        OFS_ITEM_CTRL_LOW:     reg_rdata <= item_type_ctrl_low;
        OFS_ITEM_CTRL_HIGH:    reg_rdata <= item_type_ctrl_high;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Almost-full flag
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      almost_full_flag <= 1'b0;
      af_cond_q        <= 1'b0;
    end
    else if (clk_en)
    begin
      af_cond_q <= af_cond;
      if ((!af_single && push_store && next_af_cond) || (af_cond && !af_cond_q)) // RQ14 RQ15 RQ22
      begin
        almost_full_flag <= 1'b1;
      end
      else if (rd_stat1 || (clear_on_data && rd_data)) // RQ13
      begin
        almost_full_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Proximity mode and acquisition
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode      <= SFP_NORMAL;
      near_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!near_irq_enable)
      begin
        mode <= SFP_NORMAL;
      end
      else if (led1_valid)
      begin
        mode <= (32'(led1_value) < (32'(near_detect_threshold) << NEAR_SHIFT)) ? SFP_NEAR : SFP_NORMAL; // RQ2
      end
      if (near_irq_enable && led1_valid && mode == SFP_NEAR
          && !(32'(led1_value) < (32'(near_detect_threshold) << NEAR_SHIFT)))
      begin
        near_flag <= 1'b1; // RQ5
      end
      else if (rd_stat1)
      begin
        near_flag <= 1'b0; // RQ23
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      near_mode          <= 1'b0;
      acq_item_types     <= 16'h0000;
      acq_led1_amplitude <= 8'h00;
    end
    else if (clk_en)
    begin
      near_mode <= (mode == SFP_NEAR);
      if (mode == SFP_NEAR)
      begin
        acq_item_types     <= {12'h000, LED1_TYPE}; // RQ3
        acq_led1_amplitude <= pilot_led_amplitude;
      end
      else
      begin
        acq_item_types     <= {item_type_ctrl_high, item_type_ctrl_low}; // RQ4
        acq_led1_amplitude <= led1_amplitude;
      end
    end
  end

  // ****************************************
  // Fault flags
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      led_compliance_flag <= 1'b0;
      supply_range_flag   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (led_compliance_irq_enable && sample_valid && compliance_s) // RQ6
      begin
        led_compliance_flag <= 1'b1;
      end
      else if (rd_stat1)
      begin
        led_compliance_flag <= 1'b0;
      end
      if (irq_enable_second[BIT_SUPPLY_EN] && supply_s) // RQ7
      begin
        supply_range_flag <= 1'b1;
      end
      else if (rd_stat2)
      begin
        supply_range_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic plain;
  assign plain = clk_en && !flush && !wr_widx && !wr_ridx;

  sequence s_store;
    plain && push_store;
  endsequence
  property p_write_advance;
    logic [4:0] w;
    (s_store, w = buffer_write_index) |=> buffer_write_index == w + 5'h01;
  endproperty
  a_write_advance: assert property (p_write_advance) else $error("write index did not advance"); // RQ8

  property p_lost_sat;
    clk_en && !flush && lost_sample_count == LOST_MAX |=> lost_sample_count == LOST_MAX;
  endproperty
  a_lost_sat: assert property (p_lost_sat) else $error("lost count wrapped"); // RQ9

  property p_pop_advance;
    plain && pop |=> buffer_read_index == $past(buffer_read_index) + 5'h01;
  endproperty
  a_pop_advance: assert property (p_pop_advance) else $error("read index did not advance"); // RQ10

  property p_read_write;
    clk_en && !flush && wr_ridx |=> buffer_read_index == $past(reg_wdata[4:0]);
  endproperty
  a_read_write: assert property (p_read_write) else $error("read index write lost"); // RQ11

  property p_stop_full;
    plain && push_try && full && !pop && !rollover && mode == SFP_NORMAL
      |=> buffer_write_index == $past(buffer_write_index);
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("write index moved while full"); // RQ17

  property p_roll_full;
    plain && push_over |=> fill == 6'(BUF_DEPTH) && buffer_read_index == $past(buffer_read_index) + 5'h01;
  endproperty
  a_roll_full: assert property (p_roll_full) else $error("rollover did not advance read"); // RQ16

  property p_flush;
    clk_en && buffer_enable && !enable_q |=> fill == 6'h00 && buffer_write_index == 5'h00;
  endproperty
  a_flush: assert property (p_flush) else $error("enable did not flush"); // RQ24

  property p_near_flag;
    clk_en && near_irq_enable && led1_valid && mode == SFP_NEAR && !near_flag
      && !(32'(led1_value) < (32'(near_detect_threshold) << NEAR_SHIFT))
      |=> near_flag ##1 !near_mode;
  endproperty
  a_near_flag: assert property (p_near_flag) else $error("exit from near mode not flagged"); // RQ5

  property p_supply_gate;
    clk_en && !irq_enable_second[BIT_SUPPLY_EN] && !supply_range_flag |=> !supply_range_flag;
  endproperty
  a_supply_gate: assert property (p_supply_gate) else $error("supply flag set while disabled"); // RQ7

  property p_af_clear;
    clk_en && rd_stat1 && !push_store && !(af_cond && !af_cond_q) |=> !almost_full_flag;
  endproperty
  a_af_clear: assert property (p_af_clear) else $error("almost-full not cleared"); // RQ13
endmodule : sfp_ctrl

// ---- sim/sfp_host.sv ----
/*
  Host model: drives the register port of the sample buffer block.
  Assumes the bench calls one task at a time, all on ref_clk.
*/
`timescale 1ns/10ps
module sfp_host
  import sfp_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    reg_addr  = ~a;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  // Item 1 set to the first LED before proximity use
  task automatic arm_near(input logic [3:0] led1_code);
    wr(OFS_ITEM_CTRL_LOW, {4'h2, led1_code});
  endtask : arm_near
endmodule : sfp_host

// ---- sim/tb_top.sv ----
/*
  Self-checking bench of the sample buffer block with a reference model.
  Assumes sfp_pkg and sfp_host; single 250 MHz clock.
*/
`timescale 1ns/10ps
module tb_top
  import sfp_pkg::*;
;
  localparam logic [3:0] LED1_T = 4'h1;
  logic        ref_clk, rst, reg_wr, reg_rd, sample_valid, led1_valid, near_irq_enable;
  logic        led_compliance_irq_enable, buffer_enable, led_compliance_fault, supply_range_fault;
  logic        near_mode, almost_full_flag, near_flag, led_compliance_flag, supply_range_flag;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, sample_data, near_detect_threshold;
  logic [7:0]  acq_led1_amplitude;
  logic [7:0]  pilot_led_amplitude = 8'h5A;
  logic [7:0]  led1_amplitude      = 8'hC3;
  logic [15:0] acq_item_types;
  logic [18:0] led1_value;
  logic [7:0]  mem [32];
  logic [7:0]  exp_q [$];
  int          wr_i, rd_i, fill, lost, bad_count, num_checks;
  bit          ro, near;

  sfp_host sfp_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  sfp_ctrl #(.LED1_TYPE(LED1_T)) sfp_ctrl_i (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_data(sample_data),
    .led1_valid(led1_valid), .led1_value(led1_value), .near_detect_threshold(near_detect_threshold),
    .pilot_led_amplitude(pilot_led_amplitude), .led1_amplitude(led1_amplitude),
    .near_irq_enable(near_irq_enable), .led_compliance_irq_enable(led_compliance_irq_enable),
    .buffer_enable(buffer_enable), .led_compliance_fault(led_compliance_fault),
    .supply_range_fault(supply_range_fault), .near_mode(near_mode), .acq_item_types(acq_item_types),
    .acq_led1_amplitude(acq_led1_amplitude), .almost_full_flag(almost_full_flag),
    .near_flag(near_flag), .led_compliance_flag(led_compliance_flag),
    .supply_range_flag(supply_range_flag));

  // ****************************************
  // Checking
  // ****************************************
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t level got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd

  always @(posedge ref_clk)
  begin
    if (reg_rd === 1'b1)
    begin
      #1;
      chk_rd(reg_rdata, exp_q.pop_front());
    end
  end

  // ****************************************
  // Stimulus
  // ****************************************
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfp_host_i.rd(a);
  endtask : rd

  task automatic rd_data();
    rd(OFS_DATA_PORT, (fill > 0) ? mem[rd_i] : 8'h00);
    if (fill > 0)
    begin
      rd_i = (rd_i + 1) % 32;
      fill--;
    end
  endtask : rd_data

  task automatic push();
    logic [7:0] d;
    d = 8'($urandom);
    @(posedge ref_clk);
    #1;
    sample_valid = 1'b1;
    sample_data  = d;
    @(posedge ref_clk);
    #1;
    sample_valid = 1'b0;
    sample_data  = ~d;
    if (fill < 32 || ro || near)
    begin
      mem[wr_i] = d;
      wr_i      = (wr_i + 1) % 32;
    end
    if (fill < 32)
      fill++;
    else
    begin
      if (lost < 31)
        lost++;
      if (ro || near)
        rd_i = (rd_i + 1) % 32;
    end
  endtask : push

  task automatic prox(input logic [18:0] v);
    @(posedge ref_clk);
    #1;
    led1_value = v;
    led1_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    led1_valid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : prox

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("[ERR] %0t run timed out", $time);
    test_done();
  end

  initial
  begin
    {rst, sample_valid, led1_valid, near_irq_enable, led_compliance_irq_enable} = 5'b10000;
    {buffer_enable, led_compliance_fault, supply_range_fault} = 3'b000;
    sample_data = 8'h00;
    near_detect_threshold = 8'h00;
    led1_value = 19'h7FFFF;
    void'($urandom(32'h43D7));
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    exp_q.delete();
    for (int a = 3; a < 12; a++)
      rd(8'(a), (a == 8) ? RST_BUFFER_CONFIG : 8'h00);
    sfp_host_i.wr(OFS_ITEM_CTRL_LOW, 8'h21);
    sfp_host_i.wr(OFS_ITEM_CTRL_HIGH, 8'h43);
    rd(OFS_ITEM_CTRL_LOW, 8'h21);
    rd(OFS_ITEM_CTRL_HIGH, 8'h43);
    chk(acq_item_types, 16'h4321);
    chk({8'h00, acq_led1_amplitude}, {8'h00, led1_amplitude});
    buffer_enable = 1'b1;
    repeat (2) @(posedge ref_clk);
    repeat (3) push();
    rd_data();
    rd_data();
    sfp_host_i.wr(OFS_READ_INDEX, 8'h00);
    rd_i = 0;
    fill = wr_i;
    rd_data();
    sfp_host_i.wr(OFS_READ_INDEX, 8'h03);
    rd_i = 3;
    fill = 0;
    repeat (16) push();
    chk(almost_full_flag, 16'h0);
    push();
    chk(almost_full_flag, 16'h1);
    rd(OFS_IRQ_STATUS_FIRST, 8'h00);
    chk(almost_full_flag, 16'h0);
    push();
    chk(almost_full_flag, 16'h1);
    rd_data();
    chk(almost_full_flag, 16'h1);
    while (fill < 32) push();
    repeat (3) push();
    rd(OFS_LOST_COUNT, 8'h03);
    rd(OFS_WRITE_INDEX, 8'(wr_i));
    repeat (30) push();
    rd(OFS_LOST_COUNT, {3'h0, LOST_MAX});
    sfp_host_i.wr(OFS_BUFFER_CONFIG, 8'h5F);
    ro = 1'b1;
    repeat (2) push();
    rd(OFS_READ_INDEX, 8'(rd_i));
    rd_data();
    chk(almost_full_flag, 16'h0);
    sfp_host_i.wr(OFS_BUFFER_CONFIG, 8'h7F);
    push();
    chk(almost_full_flag, 16'h0);
    sfp_host_i.wr(OFS_BUFFER_CONFIG, 8'h0F);
    ro = 1'b0;
    sfp_host_i.arm_near(LED1_T);
    {near_irq_enable, led_compliance_irq_enable, led_compliance_fault, supply_range_fault} = 4'hF;
    near_detect_threshold = 8'h01;
    prox(19'd2047);
    near = 1'b1;
    chk(near_mode, 16'h1);
    chk(acq_item_types, {12'h000, LED1_T});
    chk({8'h00, acq_led1_amplitude}, {8'h00, pilot_led_amplitude});
    while (fill < 32) push();
    push();
    rd(OFS_WRITE_INDEX, 8'(wr_i));
    chk(led_compliance_flag, 16'h1);
    chk(supply_range_flag, 16'h0);
    prox(19'd2048);
    near = 1'b0;
    chk(near_mode, 16'h0);
    chk(near_flag, 16'h1);
    rd(OFS_IRQ_STATUS_FIRST, 8'h00);
    chk(near_flag, 16'h0);
    sfp_host_i.wr(OFS_IRQ_ENABLE_SECOND, 8'h80);
    rd(OFS_IRQ_ENABLE_SECOND, 8'h80);
    repeat (8) @(posedge ref_clk);
    #1;
    chk(supply_range_flag, 16'h1);
    buffer_enable = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    buffer_enable = 1'b1;
    rd(OFS_WRITE_INDEX, 8'h00);
    rd(OFS_LOST_COUNT, 8'h00);
    repeat (2) @(posedge ref_clk);
    test_done();
  end
endmodule : tb_top
